/* rtl/adc_ctl_pkg.sv */
// Purpose: Shared constants for the converter control register block
// Assumes: APB slave, 32-bit data, 100 MHz clock
// Notes:   Offsets and field positions used by the control block
`default_nettype none
package adc_ctl_pkg;
   // Register map
   localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
   localparam logic [7:0]  RESULT_OFFSET  = 8'h04;
   localparam logic [7:0]  TIMING_OFFSET  = 8'h08;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] CTRL_WMASK     = 32'h0000_A7F7;
   // Field positions in the control register
   localparam int ENABLE_BIT   = 15;
   localparam int IDLE_BIT     = 13;
   localparam int FORMAT_LSB   = 8;
   localparam int TRIG_LSB     = 5;
   localparam int STOPAUTO_BIT = 4;
   localparam int AUTO_BIT     = 2;
   localparam int SAMPLE_BIT   = 1;
   localparam int DONE_BIT     = 0;
   // Result formats
   localparam logic [2:0] FMT_INT16   = 3'h0;
   localparam logic [2:0] FMT_SINT16  = 3'h1;
   localparam logic [2:0] FMT_FRAC16  = 3'h2;
   localparam logic [2:0] FMT_SFRAC16 = 3'h3;
   localparam logic [2:0] FMT_INT32   = 3'h4;
   localparam logic [2:0] FMT_SINT32  = 3'h5;
   localparam logic [2:0] FMT_FRAC32  = 3'h6;
   localparam logic [2:0] FMT_SFRAC32 = 3'h7;
   // Trigger sources
   localparam logic [2:0] TRIG_MANUAL = 3'h0;
   localparam logic [2:0] TRIG_EXT0   = 3'h1;
   localparam logic [2:0] TRIG_TIMER3 = 3'h2;
   localparam logic [2:0] TRIG_CHARGE_TIME = 3'h3;
   localparam logic [2:0] TRIG_AUTO   = 3'h7;
   // Auto-convert sample time reset value (sample counter target)
   localparam logic [7:0] SAMPLE_TIME_RESET = 8'h10;
   // Converter state machine
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONV   = 2'b10
   } conv_state_t;
endpackage
`default_nettype wire

/* rtl/result_formatter.sv */
// Purpose: Shapes a 10-bit conversion result into the selected output word
// Assumes: Raw result is an unsigned 10-bit code
// Notes:   Signed forms treat the raw code as offset binary around mid-scale
`timescale 1ns/1ps
`default_nettype none
module result_formatter
   import adc_ctl_pkg::*;
(
   input  wire logic [2:0]  format_in,
   input  wire logic [9:0]  raw_in,
   output logic      [31:0] word_out
);
   logic [9:0] signed_code;

   // Offset binary to two's complement by inverting the top bit
   assign signed_code = {~raw_in[9], raw_in[8:0]};

   // Format selection
   always_comb begin
      case (format_in)
         FMT_INT16:   word_out = {22'h0, raw_in};
         FMT_SINT16:  word_out = {16'h0, {6{signed_code[9]}}, signed_code};
         FMT_FRAC16:  word_out = {16'h0, raw_in, 6'h0};
         FMT_SFRAC16: word_out = {16'h0, signed_code, 6'h0};
         FMT_INT32:   word_out = {22'h0, raw_in};
         FMT_SINT32:  word_out = {{22{signed_code[9]}}, signed_code};
         FMT_FRAC32:  word_out = {raw_in, 22'h0};
         FMT_SFRAC32: word_out = {signed_code, 22'h0};
         default:     word_out = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

/* rtl/adc_ctl.sv */
// Purpose: Converter control register one with sample/convert sequencing
// Assumes: APB slave; converter core answers with a done pulse and result
// Notes:
// Notes on behaviour
// - Enable bit runs or stops the module
// - Stop-in-idle halts module during device idle
// - Format 000 gives right-aligned 16-bit integer
// - Format 010 gives left-aligned 16-bit fraction
// - Format 011 gives signed 16-bit fraction
// - Format 100 gives right-aligned 32-bit integer
// - Format 101 gives sign-extended 32-bit integer
// - Format 110 gives left-aligned 32-bit fraction
// - Format 111 gives signed 32-bit fraction
// - Source 111 uses internal counter; 100-110 reserved
// - Source 011 converts on charge-time unit event
// - Source 010 converts on timer 3 match
// - Source 001 converts on external interrupt edge
// - Source 000 converts when software clears sampling
// - Auto sampling sets sampling flag by hardware
// - Nonzero source clears sampling flag on trigger
// - Done flag set when conversion finishes
// - Software clears done only; conversion undisturbed
// - Done flag cleared when new conversion begins
// - Unimplemented control bits read zero, ignore writes
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module adc_ctl
   import adc_ctl_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Device and trigger inputs
   input  wire logic        idle_in,
   input  wire logic        external_interrupt_zero_in,
   input  wire logic        timer3_match_in,
   input  wire logic        charge_time_measurement_unit_in,
   // Converter core
   input  wire logic        conv_done_in,
   input  wire logic [9:0]  conv_result_in,
   output logic             sample_out,
   output logic             conv_start_out,
   output logic             module_on_out
);
   // Control fields
   logic              enable;
   logic              stop_in_idle;
   logic [2:0]        result_format;
   logic [2:0]        trigger_source_select;
   logic              stop_auto_sample;
   logic              auto_sample_enable;
   logic              sampling_flag;
   logic              done_flag;
   logic [7:0]        sample_time;
   logic [7:0]        sample_count;
   logic [31:0]       result_word;
   logic [31:0]       next_result;
   logic              external_interrupt_zero_last;
   conv_state_t       state;
   logic              active;
   logic              wr_ctrl;
   logic              wr_timing;
   logic              sw_clear_sample;
   logic              sw_set_sample;
   logic              sw_clear_done;
   logic              trigger_hit;
   logic              start_conv;
   logic              conv_finish;
   logic [31:0]       ctrl_word;

   // Bus decode helper
   function automatic logic mapped(input logic [7:0] addr);
      mapped = (addr == CTRL_OFFSET) || (addr == RESULT_OFFSET) ||
               (addr == TIMING_OFFSET);
   endfunction

   // Running only when enabled and not parked by idle
   assign active = enable && !(stop_in_idle && idle_in);

   // Write strobes, taken in the access cycle
   assign wr_ctrl   = psel_in && penable_in && pwrite_in && (paddr_in == CTRL_OFFSET);
   assign wr_timing = psel_in && penable_in && pwrite_in && (paddr_in == TIMING_OFFSET);
   assign sw_clear_sample = wr_ctrl && sampling_flag && !pwdata_in[SAMPLE_BIT];
   assign sw_set_sample   = wr_ctrl && pwdata_in[SAMPLE_BIT];
   assign sw_clear_done   = wr_ctrl && !pwdata_in[DONE_BIT];

   // Trigger selection; reserved codes never fire
   always_comb begin
      case (trigger_source_select)
         TRIG_MANUAL: trigger_hit = sw_clear_sample;
         TRIG_EXT0:   trigger_hit = external_interrupt_zero_in &&
                                    !external_interrupt_zero_last;
         TRIG_TIMER3: trigger_hit = timer3_match_in;
         TRIG_CHARGE_TIME: trigger_hit = charge_time_measurement_unit_in;
         TRIG_AUTO:   trigger_hit = (sample_count == sample_time);
         default:     trigger_hit = 1'b0;
      endcase
   end

   assign start_conv  = active && (state == ST_SAMPLE) && trigger_hit;
   assign conv_finish = active && (state == ST_CONV) && conv_done_in;

   // Edge detect memory for the external interrupt input
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         external_interrupt_zero_last <= 1'b0;
      end else begin
         external_interrupt_zero_last <= external_interrupt_zero_in;
      end
   end

   // Control fields written by software; reserved bits are never stored
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enable                <= 1'b0;
         stop_in_idle          <= 1'b0;
         result_format         <= 3'h0;
         trigger_source_select <= 3'h0;
         stop_auto_sample      <= 1'b0;
      end else if (wr_ctrl) begin
         enable                <= pwdata_in[ENABLE_BIT];
         stop_in_idle          <= pwdata_in[IDLE_BIT];
         result_format         <= pwdata_in[FORMAT_LSB +: 3];
         trigger_source_select <= pwdata_in[TRIG_LSB +: 3];
         stop_auto_sample      <= pwdata_in[STOPAUTO_BIT];
      end
   end

   // Auto sampling bit; hardware clear at end of conversion wins
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         auto_sample_enable <= 1'b0;
      end else if (conv_finish && stop_auto_sample) begin
         auto_sample_enable <= 1'b0;
      end else if (wr_ctrl) begin
         auto_sample_enable <= pwdata_in[AUTO_BIT];
      end
   end

   // Sample/convert sequencer
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= ST_IDLE;
      end else if (!active) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (auto_sample_enable || sw_set_sample) begin
                  state <= ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               if (start_conv) begin
                  state <= ST_CONV;
               end
            end
            ST_CONV: begin
               if (conv_finish) begin
                  state <= (auto_sample_enable && !stop_auto_sample) ?
                           ST_SAMPLE : ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Sampling flag mirrors the sequencer's sampling phase
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sampling_flag <= 1'b0;
      end else if (!active) begin
         sampling_flag <= 1'b0;
      end else if (start_conv) begin
         sampling_flag <= 1'b0;
      end else if (state == ST_IDLE && (auto_sample_enable || sw_set_sample)) begin
         sampling_flag <= 1'b1;
      end else if (conv_finish && auto_sample_enable && !stop_auto_sample) begin
         sampling_flag <= 1'b1;
      end
   end

   // Done flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         done_flag <= 1'b0;
      end else if (conv_finish) begin
         done_flag <= 1'b1;
      end else if (start_conv || sw_clear_done) begin
         done_flag <= 1'b0;
      end
   end

   // Internal sample counter for auto-convert
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sample_count <= 8'h00;
      end else if (state != ST_SAMPLE || start_conv) begin
         sample_count <= 8'h00;
      end else if (sample_count != sample_time) begin
         sample_count <= sample_count + 8'h01;
      end
   end

   // Sample time for auto-convert, software programmable
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sample_time <= SAMPLE_TIME_RESET;
      end else if (wr_timing) begin
         sample_time <= pwdata_in[7:0];
      end
   end

   // Result shaping
   result_formatter u_fmt (
      .format_in (result_format),
      .raw_in    (conv_result_in),
      .word_out  (next_result)
   );

   // Result latched at end of conversion; format in force at that time
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         result_word <= 32'h0000_0000;
      end else if (conv_finish) begin
         result_word <= next_result;
      end
   end

   // Control word as read; unimplemented bits forced low
   assign ctrl_word = {16'h0000, enable, 1'b0, stop_in_idle, 2'b00, result_format,
                       trigger_source_select, stop_auto_sample, 1'b0,
                       auto_sample_enable, sampling_flag, done_flag};

   // APB answer: no wait state, pready in the first access cycle
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= psel_in && !penable_in;
         pslverr_out <= psel_in && !penable_in && !mapped(paddr_in);
         if (psel_in && !penable_in && !pwrite_in) begin
            case (paddr_in)
               CTRL_OFFSET:   prdata_out <= ctrl_word & CTRL_WMASK;
               RESULT_OFFSET: prdata_out <= result_word;
               TIMING_OFFSET: prdata_out <= {24'h0, sample_time};
               default:       prdata_out <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Converter handshake outputs, registered
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sample_out     <= 1'b0;
         conv_start_out <= 1'b0;
         module_on_out  <= 1'b0;
      end else begin
         sample_out     <= active && (state == ST_SAMPLE) && !start_conv;
         conv_start_out <= start_conv;
         module_on_out  <= active;
      end
   end

   // Checks on flags and sequencing
   done_sets_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      conv_finish |=> done_flag)
      else $error("done flag not set");
   done_clears_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (start_conv && !conv_finish) |=> !done_flag)
      else $error("done not cleared");
   clear_keeps_conv_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (active && state == ST_CONV && sw_clear_done && !conv_finish) |=> state == ST_CONV)
      else $error("clear disturbed conversion");
   trig_clears_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      start_conv |=> !sampling_flag && conv_start_out)
      else $error("sample not ended");
   off_idle_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      !enable |=> state == ST_IDLE)
      else $error("runs while off");
   off_outputs_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      !active |=> !module_on_out && !sample_out && !conv_start_out)
      else $error("outputs live while stopped");
   idle_stop_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (stop_in_idle && idle_in) |=> !sampling_flag)
      else $error("runs in idle");
   reserved_src_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (trigger_source_select inside {3'h4, 3'h5, 3'h6}) |-> !start_conv)
      else $error("reserved source fired");
   auto_set_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (active && state == ST_IDLE && auto_sample_enable) |=> sampling_flag)
      else $error("auto sample not set");
   auto_restart_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (conv_finish && auto_sample_enable && !stop_auto_sample) |=> sampling_flag)
      else $error("no auto restart");
   stop_auto_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (conv_finish && stop_auto_sample) |=> !auto_sample_enable)
      else $error("auto not stopped");
   // Only a control read counts; prdata keeps older data on writes
   resv_zero_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (pready_out && $past(psel_in && !penable_in && !pwrite_in && paddr_in == CTRL_OFFSET))
      |-> prdata_out[31:16] == 16'h0000)
      else $error("reserved bits set");
   // Result word shape per format, taken from the latched word
   int16_shape_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (conv_finish && result_format == FMT_INT16) |=> result_word[31:10] == 22'h00_0000)
      else $error("integer 16 upper bits set");
   frac16_shape_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (conv_finish && (result_format == FMT_FRAC16 || result_format == FMT_SFRAC16))
      |=> (result_word[31:16] == 16'h0000) && (result_word[5:0] == 6'h00))
      else $error("fraction 16 shape wrong");
   int32_shape_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (conv_finish && result_format == FMT_INT32) |=> result_word[31:10] == 22'h00_0000)
      else $error("integer 32 upper bits set");
   sext32_shape_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (conv_finish && result_format == FMT_SINT32) |=> result_word[31:10] == {22{result_word[9]}})
      else $error("sign not extended");
   frac32_shape_a: assert property (
      @(posedge clk_in) disable iff (!arst_n_in)
      (conv_finish && (result_format == FMT_FRAC32 || result_format == FMT_SFRAC32))
      |=> result_word[21:0] == 22'h00_0000)
      else $error("fraction 32 low bits set");
endmodule
`default_nettype wire

/* tb/conv_core_model.sv */
// Purpose: Behavioural stand-in for the analog sampling and conversion core
// Assumes: One-cycle start pulse from the control block
// Notes:   Result bus toggles outside the done cycle, so stale data matches only every other cycle
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
   input  wire logic       clk_in,
   input  wire logic       arst_n_in,
   input  wire logic       start_in,
   input  wire logic       slow_in,
   input  wire logic [9:0] value_in,
   output logic            done_out,
   output logic      [9:0] result_out
);
   logic [3:0] cnt;
   logic       busy;
   // Conversion timer, answers after 2 or 12 cycles
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         busy       <= 1'b0;
         cnt        <= 4'h0;
         done_out   <= 1'b0;
         result_out <= 10'h000;
      end else begin
         done_out   <= 1'b0;
         result_out <= ~result_out; // Invalid outside the done cycle
         if (start_in) begin
            busy <= 1'b1;
            cnt  <= slow_in ? 4'hC : 4'h2;
         end else if (busy) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1) begin
               busy       <= 1'b0;
               done_out   <= 1'b1;
               result_out <= value_in;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* tb/adc_control_register_one_test.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: APB answer within a bounded wait; core model on the far side
// Notes:   Format 001 is left unchecked, its meaning being undocumented
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_one_test;
   import adc_ctl_pkg::*;
   logic clk_in, arst_n_in, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, cv;
   logic idle, ext_irq, tmr3, charge, done, start, son, mon, slow, err;
   logic [9:0] raw, res;
   int fails, num_checks, ndone, n0;
   adc_ctl u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .idle_in(idle),
      .external_interrupt_zero_in(ext_irq), .timer3_match_in(tmr3),
      .charge_time_measurement_unit_in(charge),
      .conv_done_in(done), .conv_result_in(res), .sample_out(son),
      .conv_start_out(start), .module_on_out(mon));
   conv_core_model u_core (.clk_in(clk_in), .arst_n_in(arst_n_in), .start_in(start),
      .slow_in(slow), .value_in(raw), .done_out(done), .result_out(res));
   // Clock, 100 MHz
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Count finished conversions seen on the core side
   always @(posedge clk_in) if (done === 1'b1) ndone++;
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_in) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk(32'h0, 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_in); // Idle cycle, so no strobe is driven twice in one step
   endtask
   // Poll control word until done is set, bounded
   task automatic wait_done;
      int n;
      n = 0;
      do begin
         apb(1'b0, CTRL_OFFSET, 32'h0);
         n++;
      end while (rd[0] !== 1'b1 && n < 40);
      if (rd[0] !== 1'b1) chk(32'h0, 32'h1);
   endtask
   task automatic fire(input int t);
      if (t == 1) ext_irq <= 1'b1; else if (t == 2) tmr3 <= 1'b1; else charge <= 1'b1;
      @(posedge clk_in);
      ext_irq <= 1'b0; tmr3 <= 1'b0; charge <= 1'b0;
   endtask
   function automatic logic [31:0] fmt_exp(input int f, input logic [9:0] r);
      logic [9:0] s;
      s = {~r[9], r[8:0]}; // Offset binary to two's complement
      case (f)
         2: return {16'h0000, r, 6'h00};
         3: return {16'h0000, s, 6'h00};
         5: return {{22{s[9]}}, s};
         6: return {r, 22'h00_0000};
         7: return {s, 22'h00_0000};
         default: return {22'h00_0000, r};
      endcase
   endfunction
   // Watchdog, far beyond the expected run of under a thousand cycles
   initial begin
      #400000;
      fails++;
      complete_run();
   end
   initial begin
      {psel, penable, pwrite, idle, ext_irq, tmr3, charge, arst_n_in} = 8'h00;
      paddr = 8'h00; pwdata = 32'h0; raw = 10'h000; slow = 1'b1;
      repeat (6) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(posedge clk_in);
      apb(1'b0, CTRL_OFFSET, 32'h0); chk(rd, CTRL_RESET);
      apb(1'b1, CTRL_OFFSET, 32'hFFFF_5808);
      apb(1'b0, CTRL_OFFSET, 32'h0); chk(rd, 32'h0000_0000);
      apb(1'b0, 8'h0C, 32'h0); chk({31'h0, err}, 32'h1);
      // Module on first; a sampling request to a module still off is ignored
      apb(1'b1, CTRL_OFFSET, 32'h8000);
      // Software-started conversions through every documented format
      for (int f = 0; f < 8; f++) if (f != 1) begin
         raw <= f[0] ? 10'h2A5 : 10'h15A;
         cv = 32'h8000 | (f << 8);
         apb(1'b1, CTRL_OFFSET, cv | 32'h2);
         apb(1'b0, CTRL_OFFSET, 32'h0); chk(rd, cv | 32'h2);
         apb(1'b1, CTRL_OFFSET, cv);
         apb(1'b1, CTRL_OFFSET, cv);
         wait_done(); chk(rd, cv | 32'h1);
         apb(1'b0, RESULT_OFFSET, 32'h0); chk(rd, fmt_exp(f, raw));
      end
      // Event triggers with automatic sampling
      for (int t = 1; t < 4; t++) begin
         cv = 32'h8004 | (t << 5);
         apb(1'b1, CTRL_OFFSET, cv);
         apb(1'b0, CTRL_OFFSET, 32'h0); chk(rd, cv | 32'h2);
         fire(t);
         apb(1'b0, CTRL_OFFSET, 32'h0); chk(rd, cv);
         wait_done(); chk(rd, cv | 32'h3);
         fire(t);
         apb(1'b0, CTRL_OFFSET, 32'h0); chk(rd, cv);
         wait_done();
         apb(1'b1, CTRL_OFFSET, 32'h0);
      end
      // Internal counter conversions, then stop automatic sampling
      slow <= 1'b0;
      apb(1'b1, TIMING_OFFSET, 32'h4);
      apb(1'b1, CTRL_OFFSET, 32'h80E4);
      n0 = ndone;
      repeat (200) @(posedge clk_in);
      chk({31'h0, (ndone - n0) > 2}, 32'h1);
      apb(1'b1, CTRL_OFFSET, 32'h80F4);
      n0 = ndone;
      for (int i = 0; i < 100 && ndone == n0; i++) @(posedge clk_in);
      repeat (4) @(posedge clk_in);
      apb(1'b0, CTRL_OFFSET, 32'h0); chk(rd & 32'h6, 32'h0);
      // Idle handling and module enable
      apb(1'b1, CTRL_OFFSET, 32'hA002);
      idle <= 1'b1;
      @(posedge clk_in); // Let the halt land before the read samples the flag
      apb(1'b0, CTRL_OFFSET, 32'h0); chk({31'h0, rd[1]}, 32'h0);
      chk({31'h0, son}, 32'h0);
      idle <= 1'b0;
      apb(1'b1, CTRL_OFFSET, 32'h8002);
      idle <= 1'b1;
      apb(1'b0, CTRL_OFFSET, 32'h0); chk({31'h0, son}, 32'h1);
      idle <= 1'b0;
      // Reserved source: no event may end sampling
      apb(1'b1, CTRL_OFFSET, 32'h80C2);
      fire(1);
      fire(2);
      fire(3);
      apb(1'b0, CTRL_OFFSET, 32'h0); chk(rd, 32'h80C2);
      apb(1'b1, CTRL_OFFSET, 32'h0000);
      @(posedge clk_in);
      chk({30'h0, mon, son}, 32'h0);
      apb(1'b1, CTRL_OFFSET, 32'h0002);
      repeat (2) @(posedge clk_in);
      chk({30'h0, mon, son}, 32'h0);
      complete_run();
   end
endmodule
`default_nettype wire
